//--- phy_mac_mode_ctrl.sv
// mac-side mode, delay and reference clock control with management target
// assumes management master drives mdc, straps stable around reset release
`timescale 1ns/10ps
`default_nettype none
module phy_mac_mode_ctrl
  import phy_mac_mode_pkg::*;
#(
  parameter logic [2:0] RMII_MODE_CODE = 3'h1,
  parameter int FIFO_DEPTH = 16
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // straps
  input wire logic [2:0] strapMacMode,
  input wire logic strapRxShift,
  input wire logic strapTxShift,
  input wire logic strapRmiiMaster,
  input wire logic [4:0] strapPhyAddr,
  // management pins
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  // reference clock input
  input wire logic crystalInput,
  // receive nibbles from the line side
  input wire logic coreRxValid,
  input wire logic [4:0] coreRxData,
  output logic coreRxReady,
  // receive pins toward the mac
  output logic rxClkPin,
  output logic [4:0] rxDataPin,
  // transmit pins from the mac
  input wire logic txClkPin,
  input wire logic [4:0] txDataPin,
  output logic coreTxValid,
  output logic [4:0] coreTxData,
  // configuration toward the datapath
  output logic [2:0] macMode,
  output logic rxShiftEn,
  output logic txShiftEn,
  output logic rmiiMasterRole,
  output logic refClkOut50,
  output logic rxd3RefClkEn,
  output logic [2:0] testMode
);
  // ==========================================================
  // input synchronisers and edge detection
  logic [8:0] syncOut;
  logic mdcS, mdioS, xtalS, txClkS;
  logic [4:0] txDataS;
  logic mdcPrev_reg, xtalPrev_reg, txClkPrev_reg;
  logic mdcRise, xtalRise, txClkRise;

  signal_sync #(.WIDTH(9)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .rawIn({mdc, mdioIn, crystalInput, txClkPin, txDataPin}),
    .stableOut(syncOut)
  );

  assign {mdcS, mdioS, xtalS, txClkS, txDataS} = syncOut;
  assign mdcRise = mdcS && !mdcPrev_reg;
  assign xtalRise = xtalS && !xtalPrev_reg;
  assign txClkRise = txClkS && !txClkPrev_reg;

  // previous levels for edge finding
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      mdcPrev_reg <= 1'b0;
      xtalPrev_reg <= 1'b0;
      txClkPrev_reg <= 1'b0;
    end
    else
    begin
      mdcPrev_reg <= mdcS;
      xtalPrev_reg <= xtalS;
      txClkPrev_reg <= txClkS;
    end
  end

  // ==========================================================
  // configuration registers
  logic strapDone_reg, strapDone_next;
  logic [4:0] phyAddr_reg, phyAddr_next;
  logic [15:0] strapStat_reg, strapStat_next;
  logic master_reg, master_next;
  logic [15:0] ctrl_reg, ctrl_next, addr_reg, addr_next;
  logic [15:0] modeA_reg, modeA_next, modeB_reg, modeB_next;
  logic [15:0] modeC_reg, modeC_next, delay_reg, delay_next;
  logic [2:0] test_reg, test_next;
  logic rxd3_reg, rxd3_next, refClk50_reg, refClk50_next;
  logic wrFire;
  logic [4:0] wrReg, regAd_reg, regAd_next;
  logic [15:0] wrData;
  logic [15:0] extValue, readVal;
  logic [2:0] modeNext;

  // strap latch once after reset release, then management writes
  always_comb
  begin
    strapDone_next = 1'b1;
    phyAddr_next = phyAddr_reg;
    strapStat_next = strapStat_reg;
    master_next = master_reg;
    ctrl_next = ctrl_reg;
    addr_next = addr_reg;
    modeA_next = modeA_reg;
    modeB_next = modeB_reg;
    modeC_next = modeC_reg;
    delay_next = delay_reg;
    test_next = test_reg;
    if (!strapDone_reg)
    begin
      phyAddr_next = strapPhyAddr;
      master_next = strapRmiiMaster;
      strapStat_next = {5'h00, strapRmiiMaster, strapTxShift, strapRxShift,
                        strapMacMode, strapPhyAddr};
      modeA_next[MODE_A_BIT] = strapMacMode[0];
      modeB_next[MODE_B_BIT] = strapMacMode[1];
      modeC_next[MODE_C_BIT] = strapMacMode[2];
      delay_next[DELAY_RX_BIT] = strapRxShift;
      delay_next[DELAY_TX_BIT] = strapTxShift;
    end
    else if (wrFire && wrReg == REG_IND_CTRL)
    begin
      ctrl_next = wrData;
    end
    else if (wrFire && wrReg == REG_IND_DATA)
    begin
      if (ctrl_reg[15:14] == FUNC_ADDR)
      begin
        addr_next = wrData;
      end
      else if (ctrl_reg[4:0] == MMD_VENDOR)
      begin
        // writes take effect at once, no reset needed
        unique case (addr_reg)
          EXT_MODE_A: modeA_next = wrData;
          EXT_MODE_B: modeB_next = wrData;
          EXT_MODE_C: modeC_next = wrData;
          EXT_DELAY: delay_next = wrData;
          default: ;
        endcase
      end
      else if (ctrl_reg[4:0] == MMD_PMA && addr_reg == EXT_TEST)
      begin
        test_next = legal_test(wrData[TEST_LSB+2:TEST_LSB]);
      end
    end
    modeNext = {modeC_next[MODE_C_BIT], modeB_next[MODE_B_BIT], modeA_next[MODE_A_BIT]};
    rxd3_next = master_next && (modeNext == RMII_MODE_CODE);
    refClk50_next = !master_next;
  end

  // register the configuration
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      strapDone_reg <= 1'b0;
      phyAddr_reg <= 5'h00;
      strapStat_reg <= 16'h0000;
      master_reg <= 1'b0;
      ctrl_reg <= CTRL_RST;
      addr_reg <= DATA_RST;
      modeA_reg <= MODE_RST;
      modeB_reg <= MODE_RST;
      modeC_reg <= MODE_RST;
      delay_reg <= DELAY_RST;
      test_reg <= TEST_RST;
      rxd3_reg <= 1'b0;
      refClk50_reg <= 1'b0;
    end
    else
    begin
      strapDone_reg <= strapDone_next;
      phyAddr_reg <= phyAddr_next;
      strapStat_reg <= strapStat_next;
      master_reg <= master_next;
      ctrl_reg <= ctrl_next;
      addr_reg <= addr_next;
      modeA_reg <= modeA_next;
      modeB_reg <= modeB_next;
      modeC_reg <= modeC_next;
      delay_reg <= delay_next;
      test_reg <= test_next;
      rxd3_reg <= rxd3_next;
      refClk50_reg <= refClk50_next;
    end
  end

  // read value of the addressed register
  always_comb
  begin
    extValue = 16'h0000;
    if (ctrl_reg[4:0] == MMD_VENDOR)
    begin
      unique case (addr_reg)
        EXT_MODE_A: extValue = modeA_reg;
        EXT_MODE_B: extValue = modeB_reg;
        EXT_MODE_C: extValue = modeC_reg;
        EXT_DELAY: extValue = delay_reg;
        EXT_STRAP: extValue = strapStat_reg;
        default: extValue = 16'h0000;
      endcase
    end
    else if (ctrl_reg[4:0] == MMD_PMA && addr_reg == EXT_TEST)
    begin
      extValue = {test_reg, 13'h0000};
    end
    readVal = 16'h0000;
    if (regAd_reg == REG_IND_CTRL)
    begin
      readVal = ctrl_reg;
    end
    else if (regAd_reg == REG_IND_DATA)
    begin
      readVal = (ctrl_reg[15:14] == FUNC_ADDR) ? addr_reg : extValue;
    end
  end

  // ==========================================================
  // management frame target
  mdio_state_type mState_reg, mState_next;
  logic [5:0] bitCnt_reg, bitCnt_next;
  logic [15:0] shift_reg, shift_next;
  logic opRead_reg, opRead_next;
  logic mdioOut_reg, mdioOut_next, mdioOe_reg, mdioOe_next;
  logic [12:0] hdr;

  // frame walk on each sampled mdc rising edge, target only
  always_comb
  begin
    mState_next = mState_reg;
    bitCnt_next = bitCnt_reg;
    shift_next = shift_reg;
    opRead_next = opRead_reg;
    regAd_next = regAd_reg;
    mdioOut_next = mdioOut_reg;
    mdioOe_next = mdioOe_reg;
    wrFire = 1'b0;
    wrReg = regAd_reg;
    wrData = {shift_reg[14:0], mdioS};
    hdr = {shift_reg[11:0], mdioS};
    if (mdcRise)
    begin
      unique case (mState_reg)
        MDIO_PRE:
        begin
          if (mdioS)
          begin
            bitCnt_next = (bitCnt_reg == PRE_MIN) ? bitCnt_reg : 6'(bitCnt_reg + 1'b1);
          end
          else if (bitCnt_reg == PRE_MIN)
          begin
            mState_next = MDIO_HDR;
            bitCnt_next = 6'h00;
            shift_next = 16'h0000;
          end
          else
          begin
            bitCnt_next = 6'h00;
          end
        end
        MDIO_HDR:
        begin
          shift_next = wrData;
          bitCnt_next = 6'(bitCnt_reg + 1'b1);
          if (bitCnt_reg == HDR_LAST)
          begin
            bitCnt_next = 6'h00;
            opRead_next = (hdr[11:10] == OP_READ);
            regAd_next = hdr[4:0];
            if (hdr[12] && (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE)
                && hdr[9:5] == phyAddr_reg)
            begin
              mState_next = MDIO_TA;
            end
            else
            begin
              mState_next = MDIO_PRE;
            end
          end
        end
        MDIO_TA:
        begin
          bitCnt_next = 6'(bitCnt_reg + 1'b1);
          if (bitCnt_reg == 6'h00 && opRead_reg)
          begin
            mdioOe_next = 1'b1;
            mdioOut_next = 1'b0;
          end
          else if (bitCnt_reg != 6'h00)
          begin
            mState_next = MDIO_DATA;
            bitCnt_next = 6'h00;
            shift_next = readVal;
            mdioOut_next = opRead_reg && readVal[15];
          end
        end
        MDIO_DATA:
        begin
          bitCnt_next = 6'(bitCnt_reg + 1'b1);
          if (opRead_reg)
          begin
            shift_next = {shift_reg[14:0], 1'b0};
            mdioOut_next = shift_reg[14];
          end
          else
          begin
            shift_next = wrData;
          end
          if (bitCnt_reg == DATA_LAST)
          begin
            wrFire = !opRead_reg;
            mState_next = MDIO_PRE;
            bitCnt_next = 6'h00;
            mdioOe_next = 1'b0;
            mdioOut_next = 1'b0;
          end
        end
      endcase
    end
  end

  // register the frame state
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      mState_reg <= MDIO_PRE;
      bitCnt_reg <= 6'h00;
      shift_reg <= 16'h0000;
      opRead_reg <= 1'b0;
      regAd_reg <= 5'h00;
      mdioOut_reg <= 1'b0;
      mdioOe_reg <= 1'b0;
    end
    else
    begin
      mState_reg <= mState_next;
      bitCnt_reg <= bitCnt_next;
      shift_reg <= shift_next;
      opRead_reg <= opRead_next;
      regAd_reg <= regAd_next;
      mdioOut_reg <= mdioOut_next;
      mdioOe_reg <= mdioOe_next;
    end
  end

  // ==========================================================
  // receive path: fifo drained at the reference clock pace
  nibble_stream_if #(.WIDTH(5)) rxIf ();
  logic rxClk_reg, rxClk_next;
  logic [4:0] rxPin_reg, rxPin_next, rxHold_reg, rxHold_next;
  logic [3:0] rxWait_reg, rxWait_next;

  stream_fifo #(.WIDTH(5), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .wrValid(coreRxValid),
    .wrData(coreRxData),
    .wrReady(coreRxReady),
    .rd(rxIf.source)
  );

  assign rxIf.ready = xtalRise;

  // clock strobe first, data after the shift delay in shift mode
  always_comb
  begin
    rxClk_next = rxIf.valid && xtalRise;
    rxPin_next = rxPin_reg;
    rxHold_next = rxHold_reg;
    rxWait_next = (rxWait_reg != 4'h0) ? 4'(rxWait_reg - 1'b1) : rxWait_reg;
    if (rxWait_reg == 4'h1)
    begin
      rxPin_next = rxHold_reg;
    end
    if (rxIf.valid && xtalRise)
    begin
      if (delay_reg[DELAY_RX_BIT])
      begin
        rxHold_next = rxIf.data;
        rxWait_next = 4'(RX_SHIFT_CYC);
      end
      else
      begin
        rxPin_next = rxIf.data;
      end
    end
  end

  // register the receive launcher
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      rxClk_reg <= 1'b0;
      rxPin_reg <= 5'h00;
      rxHold_reg <= 5'h00;
      rxWait_reg <= 4'h0;
    end
    else
    begin
      rxClk_reg <= rxClk_next;
      rxPin_reg <= rxPin_next;
      rxHold_reg <= rxHold_next;
      rxWait_reg <= rxWait_next;
    end
  end

  // ==========================================================
  // transmit path: sample at the edge or after the internal delay
  logic txValid_reg, txValid_next;
  logic [4:0] txData_reg, txData_next;
  logic [3:0] txWait_reg, txWait_next;

  always_comb
  begin
    txValid_next = 1'b0;
    txData_next = txData_reg;
    txWait_next = (txWait_reg != 4'h0) ? 4'(txWait_reg - 1'b1) : txWait_reg;
    if (txWait_reg == 4'h1)
    begin
      txValid_next = 1'b1;
      txData_next = txDataS;
    end
    if (txClkRise)
    begin
      if (delay_reg[DELAY_TX_BIT])
      begin
        txWait_next = 4'(TX_SHIFT_CYC);
      end
      else
      begin
        txValid_next = 1'b1;
        txData_next = txDataS;
      end
    end
  end

  // register the transmit sampler
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      txValid_reg <= 1'b0;
      txData_reg <= 5'h00;
      txWait_reg <= 4'h0;
    end
    else
    begin
      txValid_reg <= txValid_next;
      txData_reg <= txData_next;
      txWait_reg <= txWait_next;
    end
  end

  // ==========================================================
  // outputs, all from flops
  assign mdioOut = mdioOut_reg;
  assign mdioOe = mdioOe_reg;
  assign rxClkPin = rxClk_reg;
  assign rxDataPin = rxPin_reg;
  assign coreTxValid = txValid_reg;
  assign coreTxData = txData_reg;
  assign macMode = {modeC_reg[MODE_C_BIT], modeB_reg[MODE_B_BIT], modeA_reg[MODE_A_BIT]};
  assign rxShiftEn = delay_reg[DELAY_RX_BIT];
  assign txShiftEn = delay_reg[DELAY_TX_BIT];
  assign rmiiMasterRole = master_reg;
  assign refClkOut50 = refClk50_reg;
  assign rxd3RefClkEn = rxd3_reg;
  assign testMode = test_reg;
endmodule : phy_mac_mode_ctrl
`default_nettype wire

//--- phy_mac_mode_pkg.sv
// constants, field positions, reset values and types of the mac interface mode block
// assumes a 40 MHz core clock and clause 22 style management frames
//
// Contract
// - mac mode from strap or three register bits
// - separate rx/tx align or shift, strap then register
// - rx shift launches clock about 3 ns early, here one 25 ns core cycle before the data
// - tx shift takes aligned pins, delays internally
// - rx path defaults to shift mode
// - rmii master: 25 MHz in, 50 MHz on rxd3
// - rmii slave: 50 MHz crystal input is reference
// - rmii role fixed by strap only
// - clock output 25 MHz master, 50 MHz slave
// - transmitter test modes 1, 2, 4, 5
// - indirect write sequence stores value at address
// - indirect read sequence returns addressed register
// - device code 01 selects second space
// - latched straps readable at 0x45d
package phy_mac_mode_pkg;
  // ==========================================================
  // direct management registers
  localparam logic [4:0] REG_IND_CTRL = 5'h0d;
  localparam logic [4:0] REG_IND_DATA = 5'h0e;
  // ==========================================================
  // extended spaces and offsets
  localparam logic [4:0] MMD_VENDOR = 5'h1f;
  localparam logic [4:0] MMD_PMA = 5'h01;
  localparam logic [15:0] EXT_MODE_A = 16'h0600;
  localparam logic [15:0] EXT_DELAY = 16'h0602;
  localparam logic [15:0] EXT_MODE_B = 16'h0608;
  localparam logic [15:0] EXT_MODE_C = 16'h0648;
  localparam logic [15:0] EXT_STRAP = 16'h045d;
  localparam logic [15:0] EXT_TEST = 16'h0836;
  // ==========================================================
  // field positions
  localparam logic [1:0] FUNC_ADDR = 2'h0;
  localparam logic [1:0] FUNC_DATA = 2'h1;
  localparam int MODE_A_BIT = 3;
  localparam int MODE_B_BIT = 9;
  localparam int MODE_C_BIT = 6;
  localparam int DELAY_TX_BIT = 0;
  localparam int DELAY_RX_BIT = 1;
  localparam int TEST_LSB = 13;
  // ==========================================================
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] DELAY_RST = 16'h0002;
  localparam logic [2:0] TEST_RST = 3'h0;
  // ==========================================================
  // transmitter test modes
  localparam logic [2:0] TM_DROOP = 3'h1;
  localparam logic [2:0] TM_JITTER = 3'h2;
  localparam logic [2:0] TM_DISTORT = 3'h4;
  localparam logic [2:0] TM_PSD = 3'h5;
  // ==========================================================
  // management frame
  localparam logic [5:0] PRE_MIN = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0c;
  localparam logic [5:0] DATA_LAST = 6'h0f;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int RX_SHIFT_PS = 3000;
  localparam int TX_SHIFT_PS = 2000;
  localparam int RX_SHIFT_CYC = (RX_SHIFT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TX_SHIFT_CYC = (TX_SHIFT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum {MDIO_PRE, MDIO_HDR, MDIO_TA, MDIO_DATA} mdio_state_type;

  // keep only the defined transmitter test codes
  function automatic logic [2:0] legal_test(input logic [2:0] code);
    logic [2:0] res;
    res = TEST_RST;
    if (code == TM_DROOP || code == TM_JITTER || code == TM_DISTORT || code == TM_PSD)
    begin
      res = code;
    end
    return res;
  endfunction : legal_test
endpackage : phy_mac_mode_pkg

//--- nibble_stream_if.sv
// valid/ready stream carrier between the fifo and the pin launcher
// assumes both ends on core_clk
`timescale 1ns/10ps
`default_nettype none
interface nibble_stream_if #(parameter int WIDTH = 5);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : nibble_stream_if
`default_nettype wire

//--- signal_sync.sv
// three-flop input synchroniser with agreement filter
// assumes inputs from outside the core_clk domain
`timescale 1ns/10ps
`default_nettype none
module signal_sync #(parameter int WIDTH = 1)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // raw and settled levels
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] stableOut
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
  logic [WIDTH-1:0] out_next;

  // a bit changes once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
    end
  end

  // register the chain
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end
    else
    begin
      s1_reg <= rawIn;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign stableOut = out_reg;
endmodule : signal_sync
`default_nettype wire

//--- stream_fifo.sv
// receive nibble fifo, registered read data and flags
// assumes writer and reader on core_clk
`timescale 1ns/10ps
`default_nettype none
module stream_fifo #(parameter int WIDTH = 5, parameter int DEPTH = 16)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // filling side
  input wire logic wrValid,
  input wire logic [WIDTH-1:0] wrData,
  output logic wrReady,
  // draining side
  nibble_stream_if.source rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [AW:0] count_reg, count_next;
  logic notFull_reg, notFull_next, notEmpty_reg, notEmpty_next;
  logic [WIDTH-1:0] rdData_reg, rdData_next;
  logic push, pop;

  // pointers, count and flags
  always_comb
  begin
    push = wrValid && notFull_reg;
    pop = rd.ready && notEmpty_reg;
    wrPtr_next = push ? AW'(wrPtr_reg + 1'b1) : wrPtr_reg;
    rdPtr_next = pop ? AW'(rdPtr_reg + 1'b1) : rdPtr_reg;
    count_next = (AW+1)'(count_reg + push - pop);
    notFull_next = (count_next != (AW+1)'(DEPTH));
    notEmpty_next = (count_next != '0);
    rdData_next = (push && wrPtr_reg == rdPtr_next) ? wrData : mem[rdPtr_next];
  end

  // storage write
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wrPtr_reg] <= wrData;
    end
  end

  // state registers
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      notFull_reg <= 1'b0;
      notEmpty_reg <= 1'b0;
      rdData_reg <= '0;
    end
    else
    begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
      notFull_reg <= notFull_next;
      notEmpty_reg <= notEmpty_next;
      rdData_reg <= rdData_next;
    end
  end

  assign wrReady = notFull_reg;
  assign rd.valid = notEmpty_reg;
  assign rd.data = rdData_reg;
endmodule : stream_fifo
`default_nettype wire

//--- phy_mac_mode_ctrl_assertions.sv
// checker on the top ports of the mode control block
// assumes one core_clk domain, resetn synchronous and active low
`timescale 1ns/10ps
`default_nettype none
module phy_mac_mode_ctrl_assertions #(parameter logic [2:0] RMII_MODE_CODE = 3'h1)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // watched outputs
  input wire logic rxClkPin,
  input wire logic [4:0] rxDataPin,
  input wire logic coreTxValid,
  input wire logic mdioOut,
  input wire logic mdioOe,
  input wire logic [2:0] macMode,
  input wire logic rmiiMasterRole,
  input wire logic refClkOut50,
  input wire logic rxd3RefClkEn,
  input wire logic [2:0] testMode
);
  // ====================
  // straps settled some cycles after release
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence settled;
    resetn [*4];
  endsequence
  chk_rx_pulse: assert property (rxClkPin |=> !rxClkPin) else $error("rx clock pulse too long");
  chk_tx_pulse: assert property (coreTxValid |=> !coreTxValid) else $error("tx valid too long");
  chk_rx_data_hold: assert property ($changed(rxDataPin) |-> rxClkPin || $past(rxClkPin))
    else $error("rx data moved off launch");
  chk_role_fixed: assert property (settled |-> $stable(rmiiMasterRole))
    else $error("rmii role changed");
  chk_clk_rate: assert property (settled |-> refClkOut50 == !rmiiMasterRole)
    else $error("clock output rate wrong");
  chk_rxd3_master: assert property (rxd3RefClkEn |-> rmiiMasterRole &&
    (macMode == RMII_MODE_CODE || $past(macMode) == RMII_MODE_CODE))
    else $error("rxd3 clock outside master");
  chk_test_legal: assert property (testMode inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5})
    else $error("illegal test mode");
  chk_turn_zero: assert property ($rose(mdioOe) |-> !mdioOut)
    else $error("turnaround not zero");
endmodule : phy_mac_mode_ctrl_assertions
bind phy_mac_mode_ctrl phy_mac_mode_ctrl_assertions #(.RMII_MODE_CODE(RMII_MODE_CODE))
  phy_mac_mode_ctrl_assertions_i (.core_clk, .resetn, .rxClkPin, .rxDataPin, .coreTxValid,
  .mdioOut, .mdioOe, .macMode, .rmiiMasterRole, .refClkOut50, .rxd3RefClkEn, .testMode);
`default_nettype wire

//--- mdio_master_model.sv
// management bus master model, the only source of mdc
// assumes a pull-up on mdio and a 200 ns mdc period
`timescale 1ns/10ps
`default_nettype none
module mdio_master_model
(
  // management pins
  output logic mdc,
  output logic mdioIn,
  input wire logic mdioOut,
  input wire logic mdioOe
);
  // ====================
  // wire level from both enables, pull-up when released
  logic drv = 1'b0;
  logic bitv = 1'b1;
  initial mdc = 1'b0;
  assign mdioIn = mdioOe ? mdioOut : (drv ? bitv : 1'b1);
  // one bit, sampled at the rise
  task automatic tick(input logic b, input logic d, output logic s);
    drv = d;
    bitv = b;
    #100 mdc = 1'b1;
    s = mdioIn;
    #100 mdc = 1'b0;
  endtask : tick
  // one whole frame, msb first, mdio released on reads
  task automatic frame(input logic [4:0] pa, input logic [4:0] ra, input logic rd,
      input logic [15:0] w, output logic [15:0] r);
    logic [13:0] h;
    logic s;
    h = {2'b01, rd ? 2'b10 : 2'b01, pa, ra};
    repeat (32) tick(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) tick(h[i], 1'b1, s);
    tick(1'b1, !rd, s);
    tick(1'b0, !rd, s);
    for (int i = 15; i >= 0; i--)
    begin
      tick(w[i], !rd, s);
      r[i] = s;
    end
    drv = 1'b0;
  endtask : frame
  // extended access through control and data registers
  task automatic ext(input logic [4:0] pa, input logic [4:0] sp, input logic [15:0] a,
      input logic rd, input logic [15:0] w, output logic [15:0] r);
    frame(pa, 5'h0d, 1'b0, {11'h000, sp}, r);
    frame(pa, 5'h0e, 1'b0, a, r);
    frame(pa, 5'h0d, 1'b0, {2'b01, 9'h000, sp}, r);
    frame(pa, 5'h0e, rd, w, r);
  endtask : ext
endmodule : mdio_master_model
`default_nettype wire

//--- phy_mac_interface_mode_control_bench.sv
// top bench for the mode control block, expected values compared at each check, fifo model queue at each rx launch
// assumes the mdio master model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module phy_mac_interface_mode_control_bench;
  import phy_mac_mode_pkg::*;
  // ====================
  // stimulus and observed nets
  wire logic mdc, mdioIn, mdioOut, mdioOe, coreRxReady, rxClkPin, coreTxValid, rxShiftEn;
  wire logic txShiftEn, rmiiMasterRole, refClkOut50, rxd3RefClkEn;
  wire logic [4:0] rxDataPin, coreTxData;
  wire logic [2:0] macMode, testMode;
  logic core_clk = 1'b0, resetn = 1'b0, strapRxShift, strapTxShift, strapRmiiMaster;
  logic crystalInput = 1'b0, coreRxValid = 1'b0, txClkPin = 1'b0, pd = 1'b0;
  logic [2:0] strapMacMode;
  logic [4:0] strapPhyAddr, coreRxData = 5'h00, txDataPin = 5'h00, q[$];
  logic [15:0] r, wv[4];
  logic [15:0] ea[4] = '{EXT_MODE_A, EXT_DELAY, EXT_MODE_B, EXT_MODE_C};
  int n_mismatch = 0, checked = 0, n;
  phy_mac_mode_ctrl phy_mac_mode_ctrl_i (.core_clk, .resetn, .strapMacMode, .strapRxShift,
    .strapTxShift, .strapRmiiMaster, .strapPhyAddr, .mdc, .mdioIn, .mdioOut, .mdioOe,
    .crystalInput, .coreRxValid, .coreRxData, .coreRxReady, .rxClkPin, .rxDataPin, .txClkPin,
    .txDataPin, .coreTxValid, .coreTxData, .macMode, .rxShiftEn, .txShiftEn, .rmiiMasterRole,
    .refClkOut50, .rxd3RefClkEn, .testMode);
  mdio_master_model mdio_master_model_i (.mdc, .mdioIn, .mdioOut, .mdioOe);
  always #12.5 core_clk = ~core_clk;
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic x(input logic [4:0] sp, input logic [15:0] a, input logic rd, input logic [15:0] w);
    mdio_master_model_i.ext(strapPhyAddr, sp, a, rd, w, r);
  endtask : x
  // launched nibbles against the fifo model
  always @(posedge core_clk)
  begin
    pd <= rxClkPin;
    if ((rxShiftEn ? pd : rxClkPin) === 1'b1 && q.size() > 0) chk(16'(rxDataPin), 16'(q.pop_front()));
  end
  initial
  begin
    void'($urandom(32'h2ae7));
    {strapMacMode, strapRxShift, strapTxShift, strapRmiiMaster, strapPhyAddr} = 11'($urandom());
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    repeat (6) @(negedge core_clk);
    chk(16'({macMode, rxShiftEn, txShiftEn, refClkOut50}), 16'({strapMacMode, strapRxShift, strapTxShift, !strapRmiiMaster}));
    x(MMD_VENDOR, EXT_STRAP, 1'b1, 16'h0000);
    chk(r, {5'h00, strapRmiiMaster, strapTxShift, strapRxShift, strapMacMode, strapPhyAddr});
    x(MMD_VENDOR, EXT_DELAY, 1'b1, 16'h0000);
    chk(r, {14'h0000, strapRxShift, strapTxShift});
    for (int i = 0; i < 4; i++)
    begin
      wv[i] = 16'($urandom());
      x(MMD_VENDOR, ea[i], 1'b0, wv[i]);
      x(MMD_VENDOR, ea[i], 1'b1, 16'h0000);
      chk(r, wv[i]);
    end
    repeat (2) @(negedge core_clk);
    chk(16'({macMode, rxShiftEn, txShiftEn}), 16'({wv[3][6], wv[2][9], wv[0][3], wv[1][1:0]}));
    chk(16'({rmiiMasterRole, rxd3RefClkEn}), 16'({strapRmiiMaster, strapRmiiMaster && {wv[3][6], wv[2][9], wv[0][3]} == 3'h1}));
    x(MMD_VENDOR, 16'h0123, 1'b1, 16'h0000);
    chk(r, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      n = (i inside {1, 2, 4, 5}) ? i : 0;
      x(MMD_PMA, EXT_TEST, 1'b0, 16'(i) << 13);
      x(MMD_PMA, EXT_TEST, 1'b1, 16'h0000);
      chk(r, 16'(n) << 13);
      chk(16'(testMode), 16'(n));
    end
    n = 0;
    repeat (20)
    begin
      @(negedge core_clk);
      coreRxData = 5'($urandom());
      coreRxValid = 1'b1;
      if (coreRxReady === 1'b1) q.push_back(coreRxData);
      n += int'(coreRxReady === 1'b1);
    end
    @(negedge core_clk) coreRxValid = 1'b0;
    chk(16'(n), 16'h0010);
    repeat (20) #100 crystalInput = ~crystalInput;
    repeat (20) #100 crystalInput = ~crystalInput;
    chk(16'(q.size()), 16'h0000);
    repeat (4)
    begin
      txDataPin = 5'($urandom());
      #100 txClkPin = 1'b1;
      for (n = 0; n < 20 && coreTxValid !== 1'b1; n++) @(negedge core_clk);
      chk(16'({n == 20, coreTxData}), 16'({1'b0, txDataPin}));
      #100 txClkPin = 1'b0;
    end
    end_of_test;
  end
endmodule : phy_mac_interface_mode_control_bench
`default_nettype wire
